// [fsia_pkg.sv]
package fsia_pkg;
    // Register byte addresses on the Wishbone slave.
    localparam logic [3:0] FSIA_ADDR_STATUS = 4'h0;
    localparam logic [3:0] FSIA_ADDR_POINTER = 4'h4;
    localparam logic [3:0] FSIA_ADDR_EXC_MASK = 4'h8;
    // Status word bit positions.
    localparam int FSIA_BIT_INEXACT = 25;
    localparam int FSIA_BIT_ZERO_DIV = 24;
    localparam int FSIA_BIT_ROUND_INC = 23;
    localparam int FSIA_BIT_SUB_IN = 22;
    localparam int FSIA_BIT_SUB_RES = 21;
    localparam int FSIA_BIT_PORT_A = 20;
    localparam int FSIA_BIT_PORT_B = 19;
    localparam int FSIA_BIT_SUMMARY = 18;
    localparam int FSIA_BIT_NO_ORDER = 17;
    localparam int FSIA_BIT_SW_FLAG = 16;
    localparam int FSIA_BIT_HW_EN = 15;
    localparam int FSIA_BIT_SXO = 14;
    localparam int FSIA_BIT_OANZ = 13;
    localparam int FSIA_BIT_SUM_EN = 12;
    localparam int FSIA_BIT_SW_EN = 11;
    localparam int FSIA_BIT_THIRD_GT = 10;
    localparam int FSIA_BIT_THIRD_LT = 9;
    localparam int FSIA_BIT_SECOND_GT = 8;
    localparam int FSIA_BIT_SECOND_LT = 7;
    localparam int FSIA_BIT_FIRST_GT = 6;
    localparam int FSIA_BIT_FIRST_LT = 5;
    localparam int FSIA_BIT_HW_FLAG = 4;
    // Bit 16 of the pointer selects the space.
    localparam int FSIA_BIT_SPACE = 16;
    // Number of exception flags in the summary (bits 19..25).
    localparam int FSIA_NUM_EXC = 7;
    localparam logic [31:0] FSIA_STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] FSIA_POINTER_RESET = 32'h0000_0000;
    localparam logic [6:0] FSIA_MASK_RESET = 7'h00;
    // Bits of the status word that software may write into the flag storage.
    localparam logic [31:0] FSIA_STATUS_WMASK = 32'h03fb_07f0;
endpackage

// [fsia_evt_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Event strobes carried from the top into the flag holder.
interface fsia_evt_if;
    logic [6:0] exc_set;
    logic no_order_set;
    logic [5:0] minmax_set;
    logic hw_set;
    modport src (output exc_set, output no_order_set, output minmax_set, output hw_set);
    modport dst (input exc_set, input no_order_set, input minmax_set, input hw_set);
endinterface
`default_nettype wire

// [fsia_flags.sv]
`timescale 1ns/1ps
`default_nettype none
// Sticky event flags: hardware set wins over a software write.
module fsia_flags (
    input wire logic i_clock,
    input wire logic i_rst,
    fsia_evt_if.dst evt,
    input wire logic i_wr,
    input wire logic [31:0] i_wdata,
    output logic [31:0] o_flags
);
    import fsia_pkg::*;

    logic [31:0] set_vec;
    logic [31:0] flags_reg;
    logic [31:0] flags_next;

    // Event vector placed at each flag's bit position.
    assign set_vec = {6'h00, evt.exc_set, 1'b0, evt.no_order_set, 6'h00,
        evt.minmax_set, evt.hw_set, 4'h0};
    assign flags_next = (i_wr ? (i_wdata & FSIA_STATUS_WMASK) : flags_reg) | set_vec;
    assign o_flags = flags_reg;

    // Flag storage.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            flags_reg <= FSIA_STATUS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    AST_SET_WINS: assert property (@(posedge i_clock) disable iff (i_rst)
        evt.exc_set[0] |=> flags_reg[FSIA_BIT_PORT_B]) else $error("set lost");
endmodule
`default_nettype wire

// [fsia_top.sv]
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Inexact result sets status bit 25.
// - Zero-divisor invalid multiply sets status bit 24.
// - Rounding that grew the mantissa sets bit 23.
// - Subnormal multiplier input sets bit 22; port bits come from their own inputs.
// - Wrapped multiplier or subnormal ALU output sets bit 21.
// - Negative unsigned integer result also sets bit 21.
// - Special operand on port A sets bit 20, on port B bit 19.
// - Bit 18 is the OR of enabled exception flags.
// - Unordered comparison sets bit 17.
// - Bit 15 enables the hardware pin; bit 4 holds its flag.
// - Bit 14 is sign XOR overflow.
// - Bit 13 is overflow AND not zero.
// - Bit 12 enables summary interrupts; resets to one in coprocessor mode.
// - Bit 11 enables software interrupts; resets to zero.
// - Two-dimensional extremum search sets bit 10 above third max, 9 below min.
// - Extremum search sets bit 8 above second max, 7 below min.
// - Extremum search sets bit 6 above first max, 5 below min.
// - The pointer is loadable and drives indirect move and jump addresses.
// - The pointer clears to zero at reset.
// - Pointer bit 16 picks data or code space, or internal jump.
// - A set mask bit lets its exception reach the summary.
// - Reset clears the status word except the coprocessor summary enable and the compare-derived bits 14 and 13.
module fsia_top (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_coproc_mode,
    input wire logic i_fast_mode,
    input wire logic i_inexact,
    input wire logic i_mul_invalid,
    input wire logic i_divisor_zero,
    input wire logic i_round_grew,
    input wire logic i_mul_subnormal_in,
    input wire logic i_port_a_special,
    input wire logic i_port_b_special,
    input wire logic i_mul_wrapped,
    input wire logic i_alu_subnormal,
    input wire logic i_int_neg_unsigned,
    input wire logic i_compare_unordered,
    input wire logic i_sign_flag,
    input wire logic i_overflow_flag,
    input wire logic i_zero_flag,
    input wire logic i_minmax_active,
    input wire logic i_minmax_2d,
    input wire logic [5:0] i_minmax_cmp,
    input wire logic i_hw_irq_pin,
    input wire logic i_ptr_load,
    input wire logic [31:0] i_ptr_value,
    input wire logic i_indirect_jump,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [3:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    output logic o_irq_request,
    output logic [15:0] o_mem_address,
    output logic o_mem_data_space,
    output logic o_jump_internal,
    output logic o_flush_zero
);
    import fsia_pkg::*;

    logic [31:0] flags;
    logic [31:0] pointer_reg;
    logic [6:0] mask_reg;
    logic en_hw_reg;
    logic en_sum_reg;
    logic en_sw_reg;
    logic strap_done_reg;
    logic [31:0] rdata_reg;
    logic ack_reg;
    logic irq_reg;
    logic [15:0] addr_reg;
    logic data_space_reg;
    logic jump_int_reg;
    logic flush_reg;
    logic summary;
    logic sxo;
    logic oanz;
    logic [31:0] status_word;
    logic [6:0] exc_set;
    logic [5:0] mm_set;
    logic req;
    logic wr_go;
    logic wr_status;
    logic wr_ptr;
    logic wr_mask;
    logic [31:0] wmerge;
    logic [31:0] rd_mux;
    logic irq_next;
    logic hit_status;
    logic hit_ptr;
    logic hit_mask;

    fsia_evt_if evt_bus();

    // Byte-lane merge of write data over an old value.
    function automatic logic [31:0] fsia_merge(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Register select: true when the byte address names the given register.
    function automatic logic fsia_hit(input logic [3:0] adr, input logic [3:0] off);
        return adr == off;
    endfunction

    // Exception event decode, bit 0 = port B up to bit 6 = inexact.
    assign exc_set[6] = i_inexact;
    assign exc_set[5] = i_mul_invalid & i_divisor_zero;
    assign exc_set[4] = i_round_grew;
    assign exc_set[3] = i_mul_subnormal_in;
    assign exc_set[2] = i_mul_wrapped | i_alu_subnormal | i_int_neg_unsigned;
    assign exc_set[1] = i_port_a_special;
    assign exc_set[0] = i_port_b_special;
    // Extremum flags; the third-coordinate pair only in two-dimensional search.
    assign mm_set = i_minmax_active ?
        (i_minmax_cmp & {i_minmax_2d, i_minmax_2d, 4'hf}) : 6'h00;
    assign evt_bus.exc_set = exc_set;
    assign evt_bus.no_order_set = i_compare_unordered;
    assign evt_bus.minmax_set = mm_set;
    assign evt_bus.hw_set = i_hw_irq_pin & en_hw_reg;

    // Bus decode; a request is answered one edge after it is taken.
    assign req = i_wb_cyc & i_wb_stb & ~ack_reg;
    // A write takes effect at the edge at which the master samples ack high.
    assign wr_go = i_wb_cyc & i_wb_stb & i_wb_we & ack_reg;
    assign hit_status = fsia_hit(i_wb_adr, FSIA_ADDR_STATUS);
    assign hit_ptr = fsia_hit(i_wb_adr, FSIA_ADDR_POINTER);
    assign hit_mask = fsia_hit(i_wb_adr, FSIA_ADDR_EXC_MASK);
    assign wr_status = wr_go & hit_status;
    assign wr_ptr = wr_go & hit_ptr;
    assign wr_mask = wr_go & hit_mask;
    assign wmerge = fsia_merge(status_word, i_wb_dat, i_wb_sel);

    fsia_flags u_flags (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .evt(evt_bus),
        .i_wr(wr_status),
        .i_wdata(wmerge),
        .o_flags(flags)
    );

    // Summary and compare-derived bits.
    assign summary = |(flags[25:19] & mask_reg);
    assign sxo = i_sign_flag ^ i_overflow_flag;
    assign oanz = i_overflow_flag & ~i_zero_flag;
    always_comb begin
        status_word = flags;
        status_word[FSIA_BIT_SUMMARY] = summary;
        status_word[FSIA_BIT_HW_EN] = en_hw_reg;
        status_word[FSIA_BIT_SXO] = sxo;
        status_word[FSIA_BIT_OANZ] = oanz;
        status_word[FSIA_BIT_SUM_EN] = en_sum_reg;
        status_word[FSIA_BIT_SW_EN] = en_sw_reg;
        status_word[3:0] = 4'h0;
    end

    assign rd_mux = hit_status ? status_word :
        hit_ptr ? pointer_reg :
        hit_mask ? {25'h0000000, mask_reg} : 32'h0000_0000;
    assign irq_next = (summary & en_sum_reg) | (flags[FSIA_BIT_SW_FLAG] & en_sw_reg)
        | (flags[FSIA_BIT_HW_FLAG] & en_hw_reg);

    // Enable bits; summary enable caught from the mode strap after reset.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            en_hw_reg <= 1'b0;
            en_sum_reg <= 1'b0;
            en_sw_reg <= 1'b0;
            strap_done_reg <= 1'b0;
        end else begin
            strap_done_reg <= 1'b1;
            if (wr_status) begin
                en_hw_reg <= wmerge[FSIA_BIT_HW_EN];
                en_sum_reg <= wmerge[FSIA_BIT_SUM_EN];
                en_sw_reg <= wmerge[FSIA_BIT_SW_EN];
            end else if (!strap_done_reg) begin
                en_sum_reg <= i_coproc_mode;
            end
        end
    end

    // Pointer and exception mask.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            pointer_reg <= FSIA_POINTER_RESET;
            mask_reg <= FSIA_MASK_RESET;
        end else begin
            if (wr_ptr) begin
                pointer_reg <= fsia_merge(pointer_reg, i_wb_dat, i_wb_sel);
            end else if (i_ptr_load) begin
                pointer_reg <= i_ptr_value;
            end
            if (wr_mask) begin
                mask_reg <= i_wb_dat[6:0];
            end
        end
    end

    // Bus answer and registered outputs.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            irq_reg <= 1'b0;
            addr_reg <= 16'h0000;
            data_space_reg <= 1'b0;
            jump_int_reg <= 1'b0;
            flush_reg <= 1'b0;
        end else begin
            ack_reg <= req;
            rdata_reg <= req ? rd_mux : 32'h0000_0000;
            irq_reg <= irq_next;
            addr_reg <= pointer_reg[15:0];
            data_space_reg <= ~i_indirect_jump & pointer_reg[FSIA_BIT_SPACE];
            jump_int_reg <= i_indirect_jump & pointer_reg[FSIA_BIT_SPACE];
            flush_reg <= i_fast_mode & exc_set[2];
        end
    end

    assign o_wb_ack = ack_reg;
    assign o_wb_dat = rdata_reg;
    assign o_irq_request = irq_reg;
    assign o_mem_address = addr_reg;
    assign o_mem_data_space = data_space_reg;
    assign o_jump_internal = jump_int_reg;
    assign o_flush_zero = flush_reg;

    // Each event sets its sticky flag at the next edge; in fast mode a subnormal ALU result also raises the flush.
    AST_INEXACT: assert property (@(posedge i_clock) disable iff (i_rst)
        i_inexact |=> flags[FSIA_BIT_INEXACT])
        else $error("inexact not set");
    AST_DIV_ZERO: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_mul_invalid && i_divisor_zero) |=> flags[FSIA_BIT_ZERO_DIV])
        else $error("zero divisor not set");
    AST_ROUND_INC: assert property (@(posedge i_clock) disable iff (i_rst)
        i_round_grew |=> flags[FSIA_BIT_ROUND_INC])
        else $error("round increment not set");
    AST_SUB_IN: assert property (@(posedge i_clock) disable iff (i_rst)
        i_mul_subnormal_in |=> flags[FSIA_BIT_SUB_IN])
        else $error("subnormal input not set");
    AST_WRAP_RES: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_mul_wrapped || i_alu_subnormal) |=> flags[FSIA_BIT_SUB_RES])
        else $error("wrapped result not flagged");
    AST_FLUSH: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_fast_mode && i_alu_subnormal) |=> o_flush_zero)
        else $error("flush missing in fast mode");
    AST_SUB_RES: assert property (@(posedge i_clock) disable iff (i_rst)
        i_int_neg_unsigned |=> flags[FSIA_BIT_SUB_RES])
        else $error("subnormal result not set");
    AST_PORT_A: assert property (@(posedge i_clock) disable iff (i_rst)
        i_port_a_special |=> flags[FSIA_BIT_PORT_A])
        else $error("port A indicator not set");
    AST_PORT_B: assert property (@(posedge i_clock) disable iff (i_rst)
        i_port_b_special |=> flags[FSIA_BIT_PORT_B])
        else $error("port B indicator not set");
    AST_NO_ORDER: assert property (@(posedge i_clock) disable iff (i_rst)
        i_compare_unordered |=> flags[FSIA_BIT_NO_ORDER])
        else $error("no order not set");

    // The summary follows the enabled flags only.
    AST_SUMMARY_ON: assert property (@(posedge i_clock) disable iff (i_rst)
        (flags[FSIA_BIT_INEXACT] && mask_reg[6]) |-> status_word[FSIA_BIT_SUMMARY])
        else $error("summary missing");
    AST_SUMMARY_OFF: assert property (@(posedge i_clock) disable iff (i_rst)
        (mask_reg == 7'h00) |-> !status_word[FSIA_BIT_SUMMARY])
        else $error("summary without enabled flag");

    // The pin flag is taken only while its enable is set.
    AST_HW_SET: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_hw_irq_pin && en_hw_reg) |=> flags[FSIA_BIT_HW_FLAG])
        else $error("pin flag not set");
    AST_HW_MASKED: assert property (@(posedge i_clock) disable iff (i_rst)
        (!en_hw_reg && !wr_status && !flags[FSIA_BIT_HW_FLAG]) |=> !flags[FSIA_BIT_HW_FLAG])
        else $error("pin flag set while disabled");

    // Compare-derived bits follow their inputs in the same cycle.
    AST_SXO: assert property (@(posedge i_clock) disable iff (i_rst)
        status_word[FSIA_BIT_SXO] == (i_sign_flag ^ i_overflow_flag))
        else $error("sign xor overflow wrong");
    AST_OANZ: assert property (@(posedge i_clock) disable iff (i_rst)
        status_word[FSIA_BIT_OANZ] == (i_overflow_flag && !i_zero_flag))
        else $error("overflow and nonzero wrong");

    // Enables after reset: summary enable from the strap, the others cleared.
    AST_STRAP: assert property (@(posedge i_clock) disable iff (i_rst)
        (!strap_done_reg && !wr_status) |=> (en_sum_reg == $past(i_coproc_mode)))
        else $error("summary enable strap wrong");
    AST_EN_RESET: assert property (@(posedge i_clock)
        i_rst |=> (!en_sw_reg && !en_hw_reg))
        else $error("enable not cleared by reset");

    // Extremum flags; the third pair only in two-dimensional search.
    AST_THIRD_1D: assert property (@(posedge i_clock) disable iff (i_rst)
        (!i_minmax_2d && !wr_status && !flags[FSIA_BIT_THIRD_GT]) |=> !flags[FSIA_BIT_THIRD_GT])
        else $error("third set in 1-D");
    AST_THIRD_2D: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_minmax_active && i_minmax_2d && i_minmax_cmp[5]) |=> flags[FSIA_BIT_THIRD_GT])
        else $error("third above max not set");
    AST_SECOND: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_minmax_active && i_minmax_cmp[3]) |=> flags[FSIA_BIT_SECOND_GT])
        else $error("second above max not set");
    AST_FIRST: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_minmax_active && i_minmax_cmp[0]) |=> flags[FSIA_BIT_FIRST_LT])
        else $error("first below min not set");

    // Pointer load, reset and space decoding.
    AST_PTR_LOAD: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_ptr_load && !wr_ptr) ##1 !(i_ptr_load || wr_ptr) |=> (o_mem_address == $past(i_ptr_value[15:0], 2)))
        else $error("pointer address wrong");
    AST_PTR_RESET: assert property (@(posedge i_clock)
        i_rst |=> (pointer_reg == FSIA_POINTER_RESET))
        else $error("pointer not cleared by reset");
    AST_SPACE: assert property (@(posedge i_clock) disable iff (i_rst)
        (pointer_reg[FSIA_BIT_SPACE] && !i_indirect_jump) |=> o_mem_data_space)
        else $error("data space not selected");
    AST_JUMP_INT: assert property (@(posedge i_clock) disable iff (i_rst)
        (pointer_reg[FSIA_BIT_SPACE] && i_indirect_jump) |=> o_jump_internal)
        else $error("internal jump not selected");

    // Status word after reset and its reserved bits.
    AST_STATUS_RESET: assert property (@(posedge i_clock)
        i_rst |=> (flags == FSIA_STATUS_RESET))
        else $error("status not cleared by reset");
    AST_RESERVED: assert property (@(posedge i_clock) disable iff (i_rst)
        status_word[3:0] == 4'h0)
        else $error("reserved bits set");

    // Interrupt request from a flag with its enable.
    AST_IRQ: assert property (@(posedge i_clock) disable iff (i_rst)
        (flags[FSIA_BIT_SW_FLAG] && en_sw_reg) |=> o_irq_request)
        else $error("irq missing");
    AST_IRQ_HW: assert property (@(posedge i_clock) disable iff (i_rst)
        (flags[FSIA_BIT_HW_FLAG] && en_hw_reg) |=> o_irq_request)
        else $error("pin irq missing");
endmodule
`default_nettype wire

// [fpu_status_and_indirect_addr_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module fpu_status_and_indirect_addr_tb;
    import fsia_pkg::*;
    logic i_clock, i_rst, coproc, fast, sgn, ovf, zro, mm_act, mm_2d, hw_pin, ptr_ld, jmp;
    logic cyc, stb, we, o_wb_ack, o_irq_request, o_mem_data_space, o_jump_internal, o_flush_zero;
    logic [9:0] ev;
    logic [5:0] mm_cmp;
    logic [3:0] adr;
    logic [15:0] o_mem_address;
    logic [31:0] ptr_val, wdat, rd, o_wb_dat;
    int n_mismatch = 0;
    int total_checks = 0;
    // Status bit that each event line of ev is expected to set.
    int bitpos[10] = '{25, 24, 23, 22, 21, 21, 21, 20, 19, 17};
    fsia_top i_dut (.i_clock(i_clock), .i_rst(i_rst), .i_coproc_mode(coproc),
        .i_fast_mode(fast), .i_inexact(ev[0]), .i_mul_invalid(ev[1]), .i_divisor_zero(ev[1]),
        .i_round_grew(ev[2]), .i_mul_subnormal_in(ev[3]), .i_mul_wrapped(ev[4]),
        .i_alu_subnormal(ev[5]), .i_int_neg_unsigned(ev[6]), .i_port_a_special(ev[7]),
        .i_port_b_special(ev[8]), .i_compare_unordered(ev[9]), .i_sign_flag(sgn),
        .i_overflow_flag(ovf), .i_zero_flag(zro), .i_minmax_active(mm_act), .i_minmax_2d(mm_2d),
        .i_minmax_cmp(mm_cmp), .i_hw_irq_pin(hw_pin), .i_ptr_load(ptr_ld), .i_ptr_value(ptr_val),
        .i_indirect_jump(jmp), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
        .o_irq_request(o_irq_request), .o_mem_address(o_mem_address),
        .o_mem_data_space(o_mem_data_space), .o_jump_internal(o_jump_internal),
        .o_flush_zero(o_flush_zero));
    // Free-running 200 MHz clock.
    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Compares one value of the design against its expectation.
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One classic Wishbone cycle; the request is held until ack is sampled high.
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 50);
        if (o_wb_ack !== 1'b1) n_mismatch++;
        rd = o_wb_dat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rdchk(input string name, input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(name, exp, rd);
    endtask
    // Raises the chosen event lines for exactly one cycle.
    task automatic pulse(input logic [9:0] v);
        @(posedge i_clock);
        ev <= v;
        @(posedge i_clock);
        ev <= 10'h000;
    endtask
    task automatic do_reset(input logic c);
        @(posedge i_clock);
        i_rst <= 1'b1;
        coproc <= c;
        repeat (3) @(posedge i_clock);
        i_rst <= 1'b0;
    endtask
    task automatic irq_chk(input logic exp);
        repeat (3) @(posedge i_clock);
        chk("irq", {31'h0, exp}, {31'h0, o_irq_request});
    endtask
    // Reset values in both modes, and an unmapped address.
    task automatic t_reset();
        do_reset(1'b1);
        rdchk("status coproc", FSIA_ADDR_STATUS, 32'h0000_1000);
        do_reset(1'b0);
        rdchk("status host", FSIA_ADDR_STATUS, 32'h0000_0000);
        rdchk("pointer", FSIA_ADDR_POINTER, 32'h0000_0000);
        bus(1'b1, 4'hc, 32'hffff_ffff);
        rdchk("unmapped", 4'hc, 32'h0000_0000);
        rdchk("mask", FSIA_ADDR_EXC_MASK, 32'h0000_0000);
    endtask
    // Every event source sets its own sticky flag only.
    task automatic t_events();
        for (int i = 0; i < 10; i++) begin
            pulse(10'h001 << i);
            rdchk("event flag", FSIA_ADDR_STATUS, 32'h1 << bitpos[i]);
            bus(1'b1, FSIA_ADDR_STATUS, 32'h0000_0000);
        end
    endtask
    // Summary follows the mask; its enable drives the request.
    task automatic t_summary();
        bus(1'b1, FSIA_ADDR_EXC_MASK, 32'h0000_0040);
        pulse(10'h001);
        rdchk("summary on", FSIA_ADDR_STATUS, 32'h0204_0000);
        bus(1'b1, FSIA_ADDR_STATUS, 32'h0200_1000);
        irq_chk(1'b1);
        bus(1'b1, FSIA_ADDR_EXC_MASK, 32'h0000_0000);
        rdchk("summary off", FSIA_ADDR_STATUS, 32'h0200_1000);
        irq_chk(1'b0);
        bus(1'b1, FSIA_ADDR_STATUS, 32'h0000_0000);
    endtask
    // Software flag needs its enable; hardware pin needs its enable.
    task automatic t_irq_sources();
        bus(1'b1, FSIA_ADDR_STATUS, 32'h0001_0000);
        irq_chk(1'b0);
        bus(1'b1, FSIA_ADDR_STATUS, 32'h0001_0800);
        irq_chk(1'b1);
        bus(1'b1, FSIA_ADDR_STATUS, 32'h0000_0000);
        hw_pin <= 1'b1;
        rdchk("hw masked", FSIA_ADDR_STATUS, 32'h0000_0000);
        bus(1'b1, FSIA_ADDR_STATUS, 32'h0000_8000);
        rdchk("hw flag", FSIA_ADDR_STATUS, 32'h0000_8010);
        irq_chk(1'b1);
        hw_pin <= 1'b0;
        bus(1'b1, FSIA_ADDR_STATUS, 32'h0000_0000);
        irq_chk(1'b0);
    endtask
    // All sign, overflow and zero combinations.
    task automatic t_cond();
        logic [2:0] c;
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            @(posedge i_clock);
            {sgn, ovf, zro} <= c;
            rdchk("cond bits", FSIA_ADDR_STATUS, {17'h0, c[2] ^ c[1], c[1] & ~c[0], 13'h0});
        end
        {sgn, ovf, zro} <= 3'b000;
    endtask
    task automatic mm(input logic a, input logic d2, input logic [5:0] cmp,
        input logic [31:0] exp);
        @(posedge i_clock);
        mm_act <= a;
        mm_2d <= d2;
        mm_cmp <= cmp;
        @(posedge i_clock);
        mm_act <= 1'b0;
        mm_cmp <= 6'h00;
        rdchk("extremum", FSIA_ADDR_STATUS, exp);
        bus(1'b1, FSIA_ADDR_STATUS, 32'h0000_0000);
    endtask
    task automatic ptr_chk(input logic [15:0] a, input logic ds, input logic ji);
        repeat (3) @(posedge i_clock);
        chk("mem address", {16'h0, a}, {16'h0, o_mem_address});
        chk("space bits", {30'h0, ds, ji}, {30'h0, o_mem_data_space, o_jump_internal});
    endtask
    // Pointer load from the core and from the bus, move and jump decoding.
    task automatic t_ptr();
        @(posedge i_clock);
        ptr_val <= 32'h0001_a5c3;
        ptr_ld <= 1'b1;
        @(posedge i_clock);
        ptr_ld <= 1'b0;
        ptr_chk(16'ha5c3, 1'b1, 1'b0);
        rdchk("pointer", FSIA_ADDR_POINTER, 32'h0001_a5c3);
        jmp <= 1'b1;
        ptr_chk(16'ha5c3, 1'b0, 1'b1);
        bus(1'b1, FSIA_ADDR_POINTER, 32'h0000_5a3c);
        ptr_chk(16'h5a3c, 1'b0, 1'b0);
        do_reset(1'b0);
        ptr_chk(16'h0000, 1'b0, 1'b0);
    endtask
    // Flush only in fast mode; reserved and computed bits ignore writes.
    task automatic t_fast_reserved();
        logic seen;
        for (int f = 0; f < 2; f++) begin
            fast <= f[0];
            pulse(10'h020);
            seen = 1'b0;
            repeat (3) begin
                @(posedge i_clock);
                seen = seen | o_flush_zero;
            end
            chk("flush", {31'h0, f[0]}, {31'h0, seen});
            bus(1'b1, FSIA_ADDR_STATUS, 32'h0000_0000);
        end
        fast <= 1'b0;
        bus(1'b1, FSIA_ADDR_STATUS, 32'hffff_ffff);
        rdchk("reserved", FSIA_ADDR_STATUS, 32'h03fb_9ff0);
        bus(1'b1, FSIA_ADDR_STATUS, 32'h0000_0000);
    endtask
    // Main sequence.
    initial begin
        {i_rst, coproc, fast, sgn, ovf, zro, mm_act, mm_2d, hw_pin, ptr_ld, jmp} = 11'h400;
        {cyc, stb, we, ev, mm_cmp, adr, ptr_val, wdat} = '0;
        t_reset();
        t_events();
        t_summary();
        t_irq_sources();
        t_cond();
        mm(1'b0, 1'b1, 6'h3f, 32'h0000_0000);
        mm(1'b1, 1'b0, 6'h3f, 32'h0000_01e0);
        mm(1'b1, 1'b0, 6'h2a, 32'h0000_0140);
        mm(1'b1, 1'b1, 6'h3f, 32'h0000_07e0);
        mm(1'b1, 1'b1, 6'h25, 32'h0000_04a0);
        mm(1'b1, 1'b1, 6'h1a, 32'h0000_0340);
        t_ptr();
        t_fast_reserved();
        give_verdict();
    end
    // Cuts a hang short well after the expected run length.
    initial begin
        repeat (6000) @(posedge i_clock);
        n_mismatch++;
        give_verdict();
    end
endmodule
`default_nettype wire
